// ---- include/phycfg_pkg.sv ----
// phycfg_pkg: register map, reset values and carrier types for the phy config bank
// assumes a 16-bit management data path with word-indexed register addresses
package phycfg_pkg;
  localparam logic [4:0]  ADDR_GENERAL_CONFIG_TWO   = 5'h14;
  localparam logic [4:0]  ADDR_RECEIVE_ERROR_COUNTER = 5'h15;
  localparam logic [4:0]  ADDR_SELF_TEST  = 5'h16;
  localparam logic [15:0] RST_GENERAL_CONFIG_TWO    = 16'h29C7;
  localparam logic [15:0] RST_RECEIVE_ERROR_COUNTER  = 16'h0000;
  localparam logic [15:0] RST_SELF_TEST   = 16'h0000;
  // writable bits of self test control; 11:10 read as zero
  localparam logic [15:0] SELF_TEST_WMASK = 16'hF3FF;
  localparam int          POS_PD_EN       = 15;
  localparam int          POS_TXERR_SUP   = 14;
  localparam int          POS_IRQ_POL     = 13;
  localparam int          POS_SOFT_RST    = 12;
  localparam int          POS_THR_LO      = 10;
  localparam int          POS_DS_EN       = 9;
  localparam int          POS_DS_ENERGY   = 8;
  localparam int          POS_AN_EN       = 7;
  localparam int          POS_DS_TEN      = 6;
  localparam int          POS_CLK_LO      = 4;
  localparam int          POS_COL_FD      = 3;
  localparam int          POS_OLD_SCR     = 2;
  localparam int          POS_SEMI_M      = 1;
  localparam int          POS_SEMI_S      = 0;
  localparam int          POS_GEN_LO      = 12;
  localparam int          POS_REV_FWD     = 7;
  localparam int          POS_MII_TX      = 6;
  localparam int          POS_LPT_LO      = 2;
  localparam logic [3:0]  GEN_OFF         = 4'h0;
  localparam logic [3:0]  GEN_CONT        = 4'hF;
  localparam logic [3:0]  LPT_DIGITAL     = 4'h1;
  localparam logic [3:0]  LPT_ANALOG      = 4'h2;
  localparam logic [3:0]  LPT_EXTERNAL    = 4'h4;
  localparam logic [3:0]  LPT_REVERSE     = 4'h8;
  localparam logic [1:0]  CLK_2M5         = 2'h0;
  localparam logic [1:0]  CLK_25M         = 2'h1;

  // loop points driven to the datapath
  typedef enum {
    PHYCFG_LP_NONE, PHYCFG_LP_PRE_SCR, PHYCFG_LP_POST_SCR, PHYCFG_LP_POST_MLT3,
    PHYCFG_LP_PRE_DSP, PHYCFG_LP_DIGITAL, PHYCFG_LP_ANALOG, PHYCFG_LP_EXTERNAL,
    PHYCFG_LP_REVERSE
  } phycfg_loop_e;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } phycfg_bus_s;

  typedef struct packed {
    logic        pd_sense_en;
    logic        txerr_suppress;
    logic        serial_mac_soft_reset;
    logic [3:0]  downshift_threshold;
    logic        downshift_en;
    logic        downshift_energy_en;
    logic        serial_mac_an_en;
    logic        downshift_ten_en;
    logic        tx_clk_2m5;
    logic        tx_clk_25m;
    logic        fd_col_en;
    logic        old_scr_auto;
    logic        semi_cross_master;
    logic        semi_cross_slave;
    logic        prbs_run;
    logic        rev_loop_fwd;
    logic        mii_loop_to_cable;
    logic [8:0]  loop_onehot;
  } phycfg_ctrl_s;
endpackage : phycfg_pkg

// ---- logic/phycfg_regs.sv ----
// phycfg_regs: general config, receive error counter and self-test control bank
// assumes a same-clock management master and event pulses from the phy core
`timescale 1ns/1ps
`default_nettype none
module phycfg_regs (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // register port
  input  wire logic [4:0]           addr_i,
  input  wire logic [15:0]          wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [15:0]          rdata_o,
  // phy core status
  input  wire logic                 rx_err_i,
  input  wire logic                 speed_1g_i,
  input  wire logic                 speed_100_i,
  input  wire logic                 irq_event_i,
  input  wire logic                 col_raw_i,
  input  wire logic                 full_duplex_i,
  input  wire logic                 sgmii_txerr_raw_i,
  // controls to the phy core
  output phycfg_pkg::phycfg_ctrl_s  ctrl_o,
  output phycfg_pkg::phycfg_loop_e  loop_point_o,
  output logic                      irq_pin_o,
  output logic                      col_o,
  output logic                      sgmii_txerr_o
);

  typedef struct packed {
    logic [15:0]              cfg;
    logic [15:0]              errcnt;
    logic [15:0]              test;
    logic [15:0]              rdata;
    logic                     irq;
    logic                     col;
    logic                     txerr;
    phycfg_pkg::phycfg_ctrl_s ctrl;
    phycfg_pkg::phycfg_loop_e loop;
  } phycfg_state_s;

  phycfg_state_s s_q;
  phycfg_state_s s_d;
  logic          wr_cfg;
  logic          wr_cnt;
  logic          wr_test;
  logic [15:0]   cnt_next;

  // address decode
  assign wr_cfg  = wr_i && (addr_i == phycfg_pkg::ADDR_GENERAL_CONFIG_TWO);
  assign wr_cnt  = wr_i && (addr_i == phycfg_pkg::ADDR_RECEIVE_ERROR_COUNTER);
  assign wr_test = wr_i && (addr_i == phycfg_pkg::ADDR_SELF_TEST);

  // clear written ones first, then count; an error landing on a clear survives as 1 unless the count stood at all ones
  always_comb begin
    cnt_next = s_q.errcnt;
    if (wr_cnt) begin
      cnt_next = s_q.errcnt & ~wdata_i;
    end
    if (rx_err_i && (s_q.errcnt != 16'hFFFF)) begin
      cnt_next = wr_cnt ? (cnt_next | 16'h0001) : 16'(s_q.errcnt + 16'h0001);
    end
  end

  // next state of the whole bank
  always_comb begin
    s_d = s_q;
    s_d.errcnt = cnt_next;
    if (wr_cfg) begin
      s_d.cfg = wdata_i;
    end else begin
      s_d.cfg[phycfg_pkg::POS_SOFT_RST] = 1'b0;
    end
    if (wr_test) begin
      s_d.test = wdata_i & phycfg_pkg::SELF_TEST_WMASK;
    end
    // read data valid only the cycle after the strobe
    s_d.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        phycfg_pkg::ADDR_GENERAL_CONFIG_TWO:   s_d.rdata = s_q.cfg;
        phycfg_pkg::ADDR_RECEIVE_ERROR_COUNTER: s_d.rdata = s_q.errcnt;
        phycfg_pkg::ADDR_SELF_TEST:  s_d.rdata = s_q.test;
        default:                     s_d.rdata = 16'h0000;
      endcase
    end
    // decoded controls, registered so every output comes from a flop
    s_d.ctrl.pd_sense_en           = s_q.cfg[phycfg_pkg::POS_PD_EN];
    s_d.ctrl.txerr_suppress        = s_q.cfg[phycfg_pkg::POS_TXERR_SUP];
    s_d.ctrl.serial_mac_soft_reset = s_q.cfg[phycfg_pkg::POS_SOFT_RST];
    s_d.ctrl.downshift_threshold   = 4'(4'h1 << s_q.cfg[phycfg_pkg::POS_THR_LO +: 2]);
    s_d.ctrl.downshift_en          = s_q.cfg[phycfg_pkg::POS_DS_EN];
    s_d.ctrl.downshift_energy_en   = s_q.cfg[phycfg_pkg::POS_DS_ENERGY];
    s_d.ctrl.serial_mac_an_en      = s_q.cfg[phycfg_pkg::POS_AN_EN];
    s_d.ctrl.downshift_ten_en      = s_q.cfg[phycfg_pkg::POS_DS_TEN];
    s_d.ctrl.tx_clk_2m5 = s_q.cfg[phycfg_pkg::POS_CLK_LO +: 2] == phycfg_pkg::CLK_2M5;
    s_d.ctrl.tx_clk_25m = s_q.cfg[phycfg_pkg::POS_CLK_LO +: 2] == phycfg_pkg::CLK_25M;
    s_d.ctrl.fd_col_en             = s_q.cfg[phycfg_pkg::POS_COL_FD];
    s_d.ctrl.old_scr_auto          = s_q.cfg[phycfg_pkg::POS_OLD_SCR];
    s_d.ctrl.semi_cross_master     = s_q.cfg[phycfg_pkg::POS_SEMI_M];
    s_d.ctrl.semi_cross_slave      = s_q.cfg[phycfg_pkg::POS_SEMI_S];
    // any non-continuous code is treated as off rather than guessed
    s_d.ctrl.prbs_run = s_q.test[phycfg_pkg::POS_GEN_LO +: 4] == phycfg_pkg::GEN_CONT;
    s_d.ctrl.rev_loop_fwd      = s_q.test[phycfg_pkg::POS_REV_FWD];
    s_d.ctrl.mii_loop_to_cable = s_q.test[phycfg_pkg::POS_MII_TX];
    // loop point: PCS field wins, else one-hot point field
    s_d.loop = phycfg_pkg::PHYCFG_LP_NONE;
    if (speed_1g_i && s_q.test[0]) begin
      s_d.loop = phycfg_pkg::PHYCFG_LP_PRE_DSP;
    end else if (speed_100_i && (s_q.test[1:0] != 2'h0)) begin
      case (s_q.test[1:0])
        2'h1:    s_d.loop = phycfg_pkg::PHYCFG_LP_PRE_SCR;
        2'h2:    s_d.loop = phycfg_pkg::PHYCFG_LP_POST_SCR;
        default: s_d.loop = phycfg_pkg::PHYCFG_LP_POST_MLT3;
      endcase
    end else if (s_q.test[1:0] == 2'h0) begin
      case (s_q.test[phycfg_pkg::POS_LPT_LO +: 4])
        phycfg_pkg::LPT_DIGITAL:  s_d.loop = phycfg_pkg::PHYCFG_LP_DIGITAL;
        phycfg_pkg::LPT_ANALOG:   s_d.loop = phycfg_pkg::PHYCFG_LP_ANALOG;
        phycfg_pkg::LPT_EXTERNAL: s_d.loop = phycfg_pkg::PHYCFG_LP_EXTERNAL;
        phycfg_pkg::LPT_REVERSE:  s_d.loop = phycfg_pkg::PHYCFG_LP_REVERSE;
        default:                  s_d.loop = phycfg_pkg::PHYCFG_LP_NONE;
      endcase
    end
    s_d.ctrl.loop_onehot = 9'(9'h001 << s_d.loop);
    // pin shaping
    s_d.irq   = irq_event_i ^ s_q.cfg[phycfg_pkg::POS_IRQ_POL];
    s_d.col   = col_raw_i && (!full_duplex_i || s_q.cfg[phycfg_pkg::POS_COL_FD]);
    s_d.txerr = sgmii_txerr_raw_i && !s_q.cfg[phycfg_pkg::POS_TXERR_SUP];
  end

  // single state register; reset loads documented defaults
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_q        <= '0;
      s_q.cfg    <= phycfg_pkg::RST_GENERAL_CONFIG_TWO;
      s_q.errcnt <= phycfg_pkg::RST_RECEIVE_ERROR_COUNTER;
      s_q.test   <= phycfg_pkg::RST_SELF_TEST;
      s_q.irq    <= 1'b1;
      s_q.loop   <= phycfg_pkg::PHYCFG_LP_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o       = s_q.rdata;
  assign ctrl_o        = s_q.ctrl;
  assign loop_point_o  = s_q.loop;
  assign irq_pin_o     = s_q.irq;
  assign col_o         = s_q.col;
  assign sgmii_txerr_o = s_q.txerr;

  // soft reset bit lives exactly one cycle after a write of 1
  soft_reset_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_cfg && wdata_i[phycfg_pkg::POS_SOFT_RST] |=> s_q.cfg[phycfg_pkg::POS_SOFT_RST] ##1
    (ctrl_o.serial_mac_soft_reset && !s_q.cfg[phycfg_pkg::POS_SOFT_RST] || wr_cfg))
    else $error("soft reset not a single pulse");

  // counter clears written ones
  count_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_cnt && !rx_err_i |=> (s_q.errcnt & $past(wdata_i)) == 16'h0000)
    else $error("written ones not cleared");

  // counter advances by one and saturates
  count_step_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rx_err_i && !wr_cnt |=> s_q.errcnt == (($past(s_q.errcnt) == 16'hFFFF) ? 16'hFFFF : $past(s_q.errcnt) + 16'h0001))
    else $error("error count step wrong");

  // interrupt pin polarity follows bit 13
  irq_polarity_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    irq_event_i && s_q.cfg[phycfg_pkg::POS_IRQ_POL] |=> !irq_pin_o)
    else $error("irq polarity wrong");

  // no full-duplex collision unless enabled
  fd_collision_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    full_duplex_i && !s_q.cfg[phycfg_pkg::POS_COL_FD] |=> !col_o)
    else $error("collision shown in full duplex");

  // transmit error suppressed when bit 14 set
  txerr_suppress_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_q.cfg[phycfg_pkg::POS_TXERR_SUP] |=> !sgmii_txerr_o)
    else $error("tx error not suppressed");

  // threshold decode two cycles after a config write, whatever follows the write
  threshold_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_cfg |=> ##1 ctrl_o.downshift_threshold == 4'(4'h1 << $past(wdata_i[phycfg_pkg::POS_THR_LO +: 2], 2)))
    else $error("threshold decode wrong");

  // prbs runs only on all ones
  prbs_code_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ctrl_o.prbs_run |-> $past(s_q.test[phycfg_pkg::POS_GEN_LO +: 4]) == phycfg_pkg::GEN_CONT)
    else $error("prbs run on bad code");

  // reverse point not selected while PCS loop field is nonzero
  pcs_priority_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_q.test[1:0] != 2'h0 |=> loop_point_o != phycfg_pkg::PHYCFG_LP_REVERSE)
    else $error("point field used under pcs loop");

  // the map checks start one edge after release, since ctrl_o still shows zeros then
  pd_sense_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.pd_sense_en == $past(s_q.cfg[phycfg_pkg::POS_PD_EN]))
    else $error("detection enable not mapped");

  // suppress flag carried to the core
  txerr_flag_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.txerr_suppress == $past(s_q.cfg[phycfg_pkg::POS_TXERR_SUP]))
    else $error("tx error flag not mapped");

  // errors pass while suppression is off
  txerr_pass_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sgmii_txerr_raw_i && !s_q.cfg[phycfg_pkg::POS_TXERR_SUP] |=> sgmii_txerr_o)
    else $error("tx error lost");

  // active-high interrupt drives the pin high
  irq_active_high_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    irq_event_i && !s_q.cfg[phycfg_pkg::POS_IRQ_POL] |=> irq_pin_o)
    else $error("irq not driven high");

  // active-low pin idles high
  irq_idle_high_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !irq_event_i && s_q.cfg[phycfg_pkg::POS_IRQ_POL] |=> irq_pin_o)
    else $error("irq idle level wrong");

  // soft reset pulse only follows a set bit
  soft_reset_only_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ctrl_o.serial_mac_soft_reset |-> $past(s_q.cfg[phycfg_pkg::POS_SOFT_RST]))
    else $error("spurious soft reset");

  // threshold codes 0..3 give 1, 2, 4, 8 attempts
  threshold_value_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.downshift_threshold == ($past(s_q.cfg[11:10]) == 2'h0 ? 4'h1 :
    $past(s_q.cfg[11:10]) == 2'h1 ? 4'h2 : $past(s_q.cfg[11:10]) == 2'h2 ? 4'h4 : 4'h8))
    else $error("threshold value wrong");

  // downshift enable carried to the core
  downshift_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.downshift_en == $past(s_q.cfg[phycfg_pkg::POS_DS_EN]))
    else $error("downshift enable not mapped");

  // energy mode carried to the core
  energy_mode_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.downshift_energy_en == $past(s_q.cfg[phycfg_pkg::POS_DS_ENERGY]))
    else $error("energy mode not mapped");

  // negotiation enable carried to the core
  negotiation_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.serial_mac_an_en == $past(s_q.cfg[phycfg_pkg::POS_AN_EN]))
    else $error("negotiation enable not mapped");

  // fallback to ten carried to the core
  ten_fallback_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.downshift_ten_en == $past(s_q.cfg[phycfg_pkg::POS_DS_TEN]))
    else $error("ten fallback not mapped");

  // clock select codes 0 and 1
  clock_select_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.tx_clk_2m5 == ($past(s_q.cfg[5:4]) == phycfg_pkg::CLK_2M5) &&
    ctrl_o.tx_clk_25m == ($past(s_q.cfg[5:4]) == phycfg_pkg::CLK_25M))
    else $error("clock select wrong");

  // codes 2 and 3 stop the clock
  clock_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_q.cfg[phycfg_pkg::POS_CLK_LO + 1] |=> !ctrl_o.tx_clk_2m5 && !ctrl_o.tx_clk_25m)
    else $error("clock not stopped");

  // full-duplex collision enable carried to the core
  fd_col_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.fd_col_en == $past(s_q.cfg[phycfg_pkg::POS_COL_FD]))
    else $error("collision enable not mapped");

  // half duplex always shows collisions
  half_duplex_col_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    col_raw_i && !full_duplex_i |=> col_o)
    else $error("half duplex collision lost");

  // enabled collision shows in any duplex
  col_enabled_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    col_raw_i && s_q.cfg[phycfg_pkg::POS_COL_FD] |=> col_o)
    else $error("enabled collision lost");

  // old scrambler choice carried to the core
  old_scrambler_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.old_scr_auto == $past(s_q.cfg[phycfg_pkg::POS_OLD_SCR]))
    else $error("scrambler choice not mapped");

  // semi-cross in master mode
  semi_master_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.semi_cross_master == $past(s_q.cfg[phycfg_pkg::POS_SEMI_M]))
    else $error("master semi-cross not mapped");

  // semi-cross in slave mode
  semi_slave_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.semi_cross_slave == $past(s_q.cfg[phycfg_pkg::POS_SEMI_S]))
    else $error("slave semi-cross not mapped");

  // counter holds without error or clear
  count_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !rx_err_i && !wr_cnt |=> $stable(s_q.errcnt))
    else $error("error count drifted");

  // an error meeting a clear is not lost
  err_on_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_cnt && rx_err_i && s_q.errcnt != 16'hFFFF |=> s_q.errcnt[0])
    else $error("error lost on clear");

  // generator runs exactly on the continuous code
  prbs_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.prbs_run == ($past(s_q.test[15:12]) == phycfg_pkg::GEN_CONT))
    else $error("generator state wrong");

  // reverse-loop forwarding carried to the core
  rev_fwd_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.rev_loop_fwd == $past(s_q.test[phycfg_pkg::POS_REV_FWD]))
    else $error("reverse forward not mapped");

  // MII-loop cable copy carried to the core
  mii_cable_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.mii_loop_to_cable == $past(s_q.test[phycfg_pkg::POS_MII_TX]))
    else $error("cable copy not mapped");

  // reverse point selected with PCS loop off
  point_reverse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_q.test[1:0] == 2'h0 && s_q.test[5:2] == phycfg_pkg::LPT_REVERSE |=> loop_point_o == phycfg_pkg::PHYCFG_LP_REVERSE)
    else $error("reverse point not selected");

  // a point code that is not one-hot loops nothing
  point_invalid_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_q.test[1:0] == 2'h0 && !(s_q.test[5:2] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8})
    |=> loop_point_o == phycfg_pkg::PHYCFG_LP_NONE)
    else $error("invalid point looped");

  // one-hot copy agrees with the loop point
  onehot_match_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.loop_onehot == 9'(9'h001 << loop_point_o))
    else $error("one-hot loop copy wrong");

  // 100M PCS loop ahead of the scrambler
  pcs_100_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    speed_100_i && !speed_1g_i && s_q.test[1:0] == 2'h1 |=> loop_point_o == phycfg_pkg::PHYCFG_LP_PRE_SCR)
    else $error("100M PCS loop wrong");

  // 1G PCS loop ahead of signal processing
  pcs_1g_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    speed_1g_i && s_q.test[0] |=> loop_point_o == phycfg_pkg::PHYCFG_LP_PRE_DSP)
    else $error("1G PCS loop wrong");

  // read data stand only after a read strobe
  read_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside slot");
endmodule : phycfg_regs
`default_nettype wire

// ---- test/phycfg_host.sv ----
// phycfg_host: management host model on the register port of the config bank
// assumes the bench calls its tasks and that it shares clk_i with the bank
`timescale 1ns/1ps
`default_nettype none
module phycfg_host (
  // clock
  input  wire logic        clk_i,
  // register port
  output logic      [4:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [15:0] rdata_i
);
  // idle bus from time zero
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = '0;
  end

  // one-cycle write; self-test words are made legal first, as a careful host would
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == phycfg_pkg::ADDR_SELF_TEST) begin
      if (v[15:12] != phycfg_pkg::GEN_CONT) v[15:12] = phycfg_pkg::GEN_OFF;
      if (v[1:0] != 2'h0) v[5:2] = 4'h0;
      if (v[5:2] != phycfg_pkg::LPT_REVERSE) v[7] = 1'b0;
      v[6] = 1'b0;
    end
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= v;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe, so take them there
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask : rd_reg
endmodule : phycfg_host
`default_nettype wire

// ---- test/phy_general_config_and_self_test_regs_test.sv ----
// bench for the phy config bank: register map, decoded controls, counter, self test
// assumes phycfg_host drives the register port; the bench drives the phy core status
`timescale 1ns/1ps
`default_nettype none
module phy_general_config_and_self_test_regs_test;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        rx_err = 1'b0;
  logic        sp1g = 1'b0;
  logic        sp100 = 1'b0;
  logic        irq_ev = 1'b0;
  logic        col_raw = 1'b0;
  logic        fdx = 1'b0;
  logic        txerr_raw = 1'b0;
  logic        irq_pin;
  logic        col;
  logic        txerr;
  logic [15:0] d;
  int          err_count = 0;
  int          samples_checked = 0;
  phycfg_pkg::phycfg_ctrl_s ctrl;
  phycfg_pkg::phycfg_loop_e lp;
  // self-test table: word, speed (1=100M, 2=1G), expected loop point code
  logic [15:0] tv [9] = '{16'hF004, 16'h0C08, 16'h0010, 16'h00A0, 16'h0001, 16'h0002, 16'h0003, 16'h0003, 16'h0000};
  logic [1:0]  ts [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h0};
  int          te [9] = '{5, 6, 7, 8, 1, 2, 3, 4, 0};
  wire logic [9:0] seen = {ctrl.pd_sense_en, ctrl.txerr_suppress, ctrl.downshift_en, ctrl.downshift_energy_en,
    ctrl.serial_mac_an_en, ctrl.downshift_ten_en, ctrl.fd_col_en, ctrl.old_scr_auto, ctrl.semi_cross_master,
    ctrl.semi_cross_slave};

  // 100 MHz clock
  always #5 clk = ~clk;

  phycfg_host h (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
  phycfg_regs i_dut (.clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .rx_err_i(rx_err), .speed_1g_i(sp1g), .speed_100_i(sp100), .irq_event_i(irq_ev),
    .col_raw_i(col_raw), .full_duplex_i(fdx), .sgmii_txerr_raw_i(txerr_raw), .ctrl_o(ctrl),
    .loop_point_o(lp), .irq_pin_o(irq_pin), .col_o(col), .sgmii_txerr_o(txerr));

  // compares and helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_lp(input phycfg_pkg::phycfg_loop_e got, input int exp);
    samples_checked++;
    if (got !== phycfg_pkg::phycfg_loop_e'(exp)) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_lp
  function automatic logic [15:0] cfg_bits(input logic [15:0] v);
    return {6'h00, v[15:14], v[9:6], v[3:0]};
  endfunction : cfg_bits
  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  // reset values of controls and registers, plus an unmapped read
  task automatic t_reset();
    settle();
    settle();
    chk(16'(seen), cfg_bits(phycfg_pkg::RST_GENERAL_CONFIG_TWO));
    chk(16'({ctrl.downshift_threshold, irq_pin}), 16'h9);
    h.rd_reg(phycfg_pkg::ADDR_GENERAL_CONFIG_TWO, d);
    chk(d, phycfg_pkg::RST_GENERAL_CONFIG_TWO);
    h.rd_reg(phycfg_pkg::ADDR_RECEIVE_ERROR_COUNTER, d);
    chk(d, phycfg_pkg::RST_RECEIVE_ERROR_COUNTER);
    h.rd_reg(phycfg_pkg::ADDR_SELF_TEST, d);
    chk(d, phycfg_pkg::RST_SELF_TEST);
    h.rd_reg(5'h1F, d);
    chk(d, 16'h0000);
  endtask : t_reset

  // every threshold and clock code, other bits toggled, status inputs active
  task automatic t_cfg();
    logic [15:0] v;
    @(posedge clk);
    {irq_ev, col_raw, fdx, txerr_raw} <= 4'hF;
    for (int k = 0; k < 4; k++) begin
      v = (k[0] ? 16'hE3CF : 16'h0000) | (16'(k) << 10) | (16'(k) << 4);
      h.wr_reg(phycfg_pkg::ADDR_GENERAL_CONFIG_TWO, v);
      settle();
      chk(16'(seen), cfg_bits(v));
      chk(16'(ctrl.downshift_threshold), 16'h1 << k);
      chk(16'({ctrl.tx_clk_2m5, ctrl.tx_clk_25m}), 16'({k == 0, k == 1}));
      chk(16'({irq_pin, col, txerr}), 16'({~v[13], v[3], ~v[14]}));
      h.rd_reg(phycfg_pkg::ADDR_GENERAL_CONFIG_TWO, d);
      chk(d, v);
    end
  endtask : t_cfg

  // soft reset gives exactly one pulse and reads back cleared
  task automatic t_soft();
    logic [15:0] n;
    h.wr_reg(phycfg_pkg::ADDR_GENERAL_CONFIG_TWO, phycfg_pkg::RST_GENERAL_CONFIG_TWO | 16'h1000);
    n = 16'h0000;
    repeat (6) begin
      settle();
      n = n + 16'(ctrl.serial_mac_soft_reset);
    end
    chk(n, 16'h0001);
    chk(16'(irq_pin), 16'h0000);
    h.rd_reg(phycfg_pkg::ADDR_GENERAL_CONFIG_TWO, d);
    chk(d, phycfg_pkg::RST_GENERAL_CONFIG_TWO);
  endtask : t_soft

  // counting, partial clear by ones, saturation at all ones
  task automatic t_count();
    @(posedge clk);
    rx_err <= 1'b1;
    repeat (3) @(posedge clk);
    rx_err <= 1'b0;
    h.rd_reg(phycfg_pkg::ADDR_RECEIVE_ERROR_COUNTER, d);
    chk(d, 16'h0003);
    h.wr_reg(phycfg_pkg::ADDR_RECEIVE_ERROR_COUNTER, 16'h0001);
    h.rd_reg(phycfg_pkg::ADDR_RECEIVE_ERROR_COUNTER, d);
    chk(d, 16'h0002);
    @(posedge clk);
    rx_err <= 1'b1;
    repeat (65540) @(posedge clk);
    rx_err <= 1'b0;
    h.rd_reg(phycfg_pkg::ADDR_RECEIVE_ERROR_COUNTER, d);
    chk(d, 16'hFFFF);
    h.wr_reg(phycfg_pkg::ADDR_RECEIVE_ERROR_COUNTER, 16'hFFFF);
    h.rd_reg(phycfg_pkg::ADDR_RECEIVE_ERROR_COUNTER, d);
    chk(d, 16'h0000);
  endtask : t_count

  // every loop point, generator off and continuous codes, and pcs loop at both speeds
  task automatic t_test();
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      sp100 <= (ts[i] == 2'h1);
      sp1g  <= (ts[i] == 2'h2);
      h.wr_reg(phycfg_pkg::ADDR_SELF_TEST, tv[i]);
      settle();
      chk_lp(lp, te[i]);
      chk(16'({ctrl.prbs_run, ctrl.rev_loop_fwd, ctrl.mii_loop_to_cable}), 16'({tv[i][15:12] == 4'hF, tv[i][7], 1'b0}));
      chk(16'(ctrl.loop_onehot), 16'h1 << te[i]);
      h.rd_reg(phycfg_pkg::ADDR_SELF_TEST, d);
      chk(d, tv[i] & phycfg_pkg::SELF_TEST_WMASK);
    end
  endtask : t_test

  // verdict and end of run
  task automatic results();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_cfg();
    t_soft();
    t_count();
    t_test();
    results();
  end

  // watchdog: the run needs about 65700 cycles
  initial begin
    #1000000;
    err_count++;
    results();
  end
endmodule : phy_general_config_and_self_test_regs_test
`default_nettype wire
